/* File: bflw_pkg.sv */
// package: constants, register map and carriers for the brake feedback load watch
package bflw_pkg;

  // ==========================================================================
  // timing
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned RESTART_STEP_NS = 10000000; // restart delay step of 10 ms
  localparam int unsigned RESTART_STEP_CYCLES = RESTART_STEP_NS / CLK_PERIOD_NS;
  localparam logic [10:0] RESTART_MAX_STEPS = 11'h5DC; // 15.00 s

  // ==========================================================================
  // register map (byte addresses)
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_THRESH = 8'h04;
  localparam logic [7:0] ADDR_RESTART = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;

  // control fields
  localparam int unsigned CTRL_FB_ABS = 0;
  localparam int unsigned CTRL_LOAD_MV = 1;
  localparam int unsigned CTRL_ZS_PRIO = 2;
  localparam int unsigned CTRL_ERR_CLR = 8;

  // status fields
  localparam int unsigned ST_BF_ERR = 0;
  localparam int unsigned ST_LM_ERR = 1;
  localparam int unsigned ST_BC_WARN = 2;
  localparam int unsigned ST_LM_WARN = 3;
  localparam int unsigned ST_ZS_HOLD = 4;
  localparam int unsigned ST_OUT_SEQ = 5;

  // reset values
  localparam logic [2:0] CTRL_RESET = 3'h0;
  localparam logic [15:0] THRESH_RESET = 16'h0000; // zero means monitoring off
  localparam logic [10:0] RESTART_RESET = 11'h000;

  // operating states that matter to the monitor
  localparam logic [3:0] OPST_SWITCH_ON_DIS = 4'h2;
  localparam logic [3:0] OPST_READY = 4'h3;
  localparam logic [3:0] OPST_SWITCHED_ON = 4'h4;
  localparam logic [3:0] OPST_OP_ENABLED = 4'h5;
  localparam logic [3:0] OPST_QUICK_STOP = 4'h6;
  localparam logic [3:0] OPST_FAULT_REACT = 4'h7;
  localparam logic [3:0] OPST_FAULT = 4'h8;

  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic closedLoop;       // speed loop closed on encoder feedback
    logic brakeEngaging;    // brake engage sequence under way
    logic engageTimeEnd;    // one-cycle pulse, engage time ran out
    logic contactOpen;      // brake contact reads open
    logic relayOpen;        // brake relay feedback reads open
    logic brakeSeqActive;   // any brake sequence under way
    logic motionCmd;        // a motion command is present
    logic newRunCmd;        // one-cycle pulse, fresh run command
    logic stoActive;        // safe torque off active
    logic driveLock;        // drive lock requested
    logic errorTrig;        // another error triggered in the drive
    logic cia402Profile;    // command profile is cia402
    logic [3:0] opState;    // drive operating state
    logic [15:0] speedAbs;  // measured speed magnitude
  } bflw_drive_t;

  typedef struct packed {
    logic brakeFeedbackError;
    logic loadMovementError;
    logic brakeContactWarning;
    logic loadMovementWarning;
    logic zeroSpeedHold;
    logic releaseInhibit;
  } bflw_report_t;

  typedef enum logic [2:0] {
    BFLW_RUN = 3'h1,
    BFLW_HOLD = 3'h2,
    BFLW_LOCK = 3'h4
  } bflw_state_t;

endpackage : bflw_pkg

/* File: bflw_brake_feedback_load_watch.sv */
// brake feedback check and uncommanded load movement watch with axi4-lite registers
//
// Functional notes
// - feedback-absence option counts only under closed-loop control.
// - option 0: both feedbacks open before engage end, else lock brake feedback error.
// - option 1: failure raises brake contact warning and holds zero speed.
// - movement watch only closed loop, after restart delay following a brake sequence.
// - uncommanded movement is speed above threshold with no motion command.
// - load movement option 0: detection triggers load movement error.
// - option 0: watch in every state except 2, 7 and 8.
// - option 1: detection holds zero speed, no brake release, raises movement warning.
// - threshold zero disables watch; a zero write to both threshold bytes refused while load movement option is 1.
// - zero-speed hold ends on new run, safe torque off or drive lock.
module bflw_brake_feedback_load_watch
  import bflw_pkg::*;
#(
  parameter int unsigned STEP_CYCLES = RESTART_STEP_CYCLES
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // drive side
  input wire bflw_drive_t drive,
  output bflw_report_t report
);

  if (STEP_CYCLES < 1 || STEP_CYCLES > 32'h00FFFFFF) begin : g_chk
    $error("STEP_CYCLES out of range");
  end

  // ==========================================================================
  // registers and state
  logic [2:0] ctrl_q, ctrl_d;
  logic [15:0] thresh_q, thresh_d;
  logic [10:0] restart_q, restart_d;
  logic bcWarn_q, bcWarn_d;
  logic lmWarn_q, lmWarn_d;
  logic bfErr_q, bfErr_d;
  logic lmErr_q, lmErr_d;
  bflw_state_t state_q, state_d;
  logic [23:0] tick_q, tick_d;
  logic [10:0] remain_q, remain_d;
  logic awHave_q, awHave_d;
  logic wHave_q, wHave_d;
  logic [7:0] awAddr_q, awAddr_d;
  logic [31:0] wData_q, wData_d;
  logic [3:0] wStrb_q, wStrb_d;
  logic bValid_q, bValid_d;
  logic [1:0] bResp_q, bResp_d;
  logic rValid_q, rValid_d;
  logic [31:0] rData_q, rData_d;
  logic [1:0] rResp_q, rResp_d;
  bflw_report_t report_q, report_d;

  logic outsideSeq;
  logic stateOk;
  logic moveSeen;
  logic engageFail;
  logic doWrite;
  logic errClear;
  logic [31:0] statusWord;

  // ==========================================================================
  // event detection
  always_comb begin
    // restart delay elapsed and no brake sequence under way
    outsideSeq = !drive.brakeSeqActive && (remain_q == 11'h000);
    // operating states in which the watch runs
    if (!ctrl_q[CTRL_LOAD_MV] || ctrl_q[CTRL_ZS_PRIO]) begin
      stateOk = (drive.opState != OPST_FAULT_REACT) && (drive.opState != OPST_FAULT);
      if (!ctrl_q[CTRL_LOAD_MV]) begin
        stateOk = stateOk && (drive.opState != OPST_SWITCH_ON_DIS);
      end
    end else if (drive.cia402Profile) begin
      stateOk = (drive.opState == OPST_OP_ENABLED) || (drive.opState == OPST_QUICK_STOP);
    end else begin
      stateOk = (drive.opState == OPST_READY) || (drive.opState == OPST_SWITCHED_ON)
        || (drive.opState == OPST_OP_ENABLED);
    end
    // speed above threshold with no command; zero threshold turns it off
    moveSeen = drive.closedLoop && outsideSeq && stateOk && !drive.motionCmd
      && (thresh_q != THRESH_RESET) && (drive.speedAbs > thresh_q);
    // either feedback still closed when the engage time ends
    engageFail = drive.closedLoop && drive.brakeEngaging && drive.engageTimeEnd
      && !(drive.contactOpen && drive.relayOpen);
  end

  // ==========================================================================
  // restart delay counter: reloaded during a brake sequence
  always_comb begin
    tick_d = tick_q;
    remain_d = remain_q;
    if (drive.brakeSeqActive) begin
      remain_d = restart_q;
      tick_d = 24'h000000;
    end else if (remain_q != 11'h000) begin
      if (tick_q == 24'(STEP_CYCLES - 1)) begin
        tick_d = 24'h000000;
        remain_d = remain_q - 11'h001;
      end else begin
        tick_d = tick_q + 24'h000001;
      end
    end
  end

  // ==========================================================================
  // supervision state machine, errors and warnings
  always_comb begin
    state_d = state_q;
    bfErr_d = bfErr_q;
    lmErr_d = lmErr_q;
    bcWarn_d = bcWarn_q;
    lmWarn_d = lmWarn_q;
    // software clears sticky warnings by writing one; a new event wins
    if (doWrite && awAddr_q == ADDR_STATUS && wStrb_q[0]) begin
      if (wData_q[ST_BC_WARN]) bcWarn_d = 1'b0;
      if (wData_q[ST_LM_WARN]) lmWarn_d = 1'b0;
    end
    if (errClear) begin
      bfErr_d = 1'b0;
      lmErr_d = 1'b0;
    end
    case (state_q)
      BFLW_RUN: begin
        if (engageFail && !ctrl_q[CTRL_FB_ABS]) begin
          bfErr_d = 1'b1;
          state_d = BFLW_LOCK;
        end else if (moveSeen && !ctrl_q[CTRL_LOAD_MV]) begin
          lmErr_d = 1'b1;
          state_d = BFLW_LOCK;
        end else if (engageFail || moveSeen) begin
          state_d = BFLW_HOLD;
        end
      end
      BFLW_HOLD: begin
        // hold yields to run, sto, lock, and to errors without priority
        if (drive.newRunCmd || drive.stoActive || drive.driveLock
            || (drive.errorTrig && !ctrl_q[CTRL_ZS_PRIO])) begin
          state_d = BFLW_RUN;
        end
      end
      BFLW_LOCK: begin
        if (errClear) begin
          state_d = BFLW_RUN;
        end
      end
      default: state_d = BFLW_RUN;
    endcase
    if (engageFail && ctrl_q[CTRL_FB_ABS]) bcWarn_d = 1'b1;
    if (moveSeen && ctrl_q[CTRL_LOAD_MV]) lmWarn_d = 1'b1;
    report_d.brakeFeedbackError = bfErr_d;
    report_d.loadMovementError = lmErr_d;
    report_d.brakeContactWarning = bcWarn_d;
    report_d.loadMovementWarning = lmWarn_d;
    report_d.zeroSpeedHold = (state_d == BFLW_HOLD);
    report_d.releaseInhibit = (state_d == BFLW_HOLD);
  end

  // ==========================================================================
  // axi4-lite slave
  always_comb begin
    statusWord = 32'h00000000;
    statusWord[ST_BF_ERR] = bfErr_q;
    statusWord[ST_LM_ERR] = lmErr_q;
    statusWord[ST_BC_WARN] = bcWarn_q;
    statusWord[ST_LM_WARN] = lmWarn_q;
    statusWord[ST_ZS_HOLD] = (state_q == BFLW_HOLD);
    statusWord[ST_OUT_SEQ] = outsideSeq;
  end

  assign s_axi_awready = !awHave_q;
  assign s_axi_wready = !wHave_q;
  assign s_axi_arready = !rValid_q;
  assign doWrite = awHave_q && wHave_q && !bValid_q;
  assign errClear = doWrite && awAddr_q == ADDR_CTRL && wStrb_q[1] && wData_q[CTRL_ERR_CLR];

  always_comb begin
    awHave_d = awHave_q;
    wHave_d = wHave_q;
    awAddr_d = awAddr_q;
    wData_d = wData_q;
    wStrb_d = wStrb_q;
    bValid_d = bValid_q;
    bResp_d = bResp_q;
    rValid_d = rValid_q;
    rData_d = rData_q;
    rResp_d = rResp_q;
    ctrl_d = ctrl_q;
    thresh_d = thresh_q;
    restart_d = restart_q;
    if (s_axi_awvalid && !awHave_q) begin
      awHave_d = 1'b1;
      awAddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && !wHave_q) begin
      wHave_d = 1'b1;
      wData_d = s_axi_wdata;
      wStrb_d = s_axi_wstrb;
    end
    if (doWrite) begin
      awHave_d = 1'b0;
      wHave_d = 1'b0;
      bValid_d = 1'b1;
      bResp_d = RESP_OKAY;
      case (awAddr_q)
        ADDR_CTRL: begin
          if (wStrb_q[0]) begin
            // load movement option 1 needs a live threshold
            if (wData_q[CTRL_LOAD_MV] && thresh_q == THRESH_RESET) begin
              bResp_d = RESP_SLVERR;
            end else begin
              ctrl_d = wData_q[2:0];
            end
          end
        end
        ADDR_THRESH: begin
          if (wStrb_q[1:0] == 2'h3 && wData_q[15:0] == THRESH_RESET
              && ctrl_q[CTRL_LOAD_MV]) begin
            bResp_d = RESP_SLVERR;
          end else begin
            if (wStrb_q[0]) thresh_d[7:0] = wData_q[7:0];
            if (wStrb_q[1]) thresh_d[15:8] = wData_q[15:8];
          end
        end
        ADDR_RESTART: begin
          if (wStrb_q[1:0] == 2'h3) begin
            if (wData_q[15:0] > 16'(RESTART_MAX_STEPS)) begin
              bResp_d = RESP_SLVERR;
            end else begin
              restart_d = wData_q[10:0];
            end
          end
        end
        ADDR_STATUS: ;
        default: bResp_d = RESP_SLVERR;
      endcase
    end else if (bValid_q && s_axi_bready) begin
      bValid_d = 1'b0;
    end
    if (s_axi_arvalid && !rValid_q) begin
      rValid_d = 1'b1;
      rResp_d = RESP_OKAY;
      case (s_axi_araddr)
        ADDR_CTRL: rData_d = {29'h00000000, ctrl_q};
        ADDR_THRESH: rData_d = {16'h0000, thresh_q};
        ADDR_RESTART: rData_d = {21'h000000, restart_q};
        ADDR_STATUS: rData_d = statusWord;
        default: begin
          rData_d = 32'h00000000;
          rResp_d = RESP_SLVERR;
        end
      endcase
    end else if (rValid_q && s_axi_rready) begin
      rValid_d = 1'b0;
    end
  end

  assign s_axi_bvalid = bValid_q;
  assign s_axi_bresp = bResp_q;
  assign s_axi_rvalid = rValid_q;
  assign s_axi_rdata = rData_q;
  assign s_axi_rresp = rResp_q;
  assign report = report_q;

  // ==========================================================================
  // state registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctrl_q <= CTRL_RESET;
      thresh_q <= THRESH_RESET;
      restart_q <= RESTART_RESET;
      bcWarn_q <= 1'b0;
      lmWarn_q <= 1'b0;
      bfErr_q <= 1'b0;
      lmErr_q <= 1'b0;
      state_q <= BFLW_RUN;
      tick_q <= 24'h000000;
      remain_q <= 11'h000;
      awHave_q <= 1'b0;
      wHave_q <= 1'b0;
      awAddr_q <= 8'h00;
      wData_q <= 32'h00000000;
      wStrb_q <= 4'h0;
      bValid_q <= 1'b0;
      bResp_q <= RESP_OKAY;
      rValid_q <= 1'b0;
      rData_q <= 32'h00000000;
      rResp_q <= RESP_OKAY;
      report_q <= '0;
    end else begin
      ctrl_q <= ctrl_d;
      thresh_q <= thresh_d;
      restart_q <= restart_d;
      bcWarn_q <= bcWarn_d;
      lmWarn_q <= lmWarn_d;
      bfErr_q <= bfErr_d;
      lmErr_q <= lmErr_d;
      state_q <= state_d;
      tick_q <= tick_d;
      remain_q <= remain_d;
      awHave_q <= awHave_d;
      wHave_q <= wHave_d;
      awAddr_q <= awAddr_d;
      wData_q <= wData_d;
      wStrb_q <= wStrb_d;
      bValid_q <= bValid_d;
      bResp_q <= bResp_d;
      rValid_q <= rValid_d;
      rData_q <= rData_d;
      rResp_q <= rResp_d;
      report_q <= report_d;
    end
  end

endmodule : bflw_brake_feedback_load_watch

/* File: bflw_chk.sv */
// checker: properties of the brake feedback load watch
module bflw_chk
  import bflw_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // bus and drive side
  input wire logic s_axi_wvalid,
  input wire bflw_drive_t drive,
  input wire bflw_report_t report
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  // ========
  // causes, now and one cycle back
  wire logic failNow = drive.closedLoop && drive.brakeEngaging && drive.engageTimeEnd
    && !(drive.contactOpen && drive.relayOpen);
  wire logic mvNow = drive.closedLoop && !drive.brakeSeqActive && !drive.motionCmd
    && drive.speedAbs != 16'h0000 && drive.opState != OPST_FAULT_REACT
    && drive.opState != OPST_FAULT;
  logic failQ;
  logic mvQ;
  logic errQ;
  always_ff @(posedge clk_sys) begin
    failQ <= failNow;
    mvQ <= mvNow;
    errQ <= mvNow && drive.opState != OPST_SWITCH_ON_DIS;
  end
  sequence s_fail;
    failNow;
  endsequence
  sequence s_stop;
    report.zeroSpeedHold && (drive.newRunCmd || drive.stoActive || drive.driveLock);
  endsequence

  // ========
  // properties
  property p_fail;
    s_fail |=> report.brakeFeedbackError || report.brakeContactWarning;
  endproperty
  a_fail: assert property (p_fail)
    else $error("engage failure not reported");
  property p_fbRise;
    $rose(report.brakeFeedbackError) |-> failQ;
  endproperty
  a_fbRise: assert property (p_fbRise)
    else $error("feedback error without cause");
  property p_bcRise;
    $rose(report.brakeContactWarning) |-> failQ;
  endproperty
  a_bcRise: assert property (p_bcRise)
    else $error("contact warning without cause");
  property p_lmRise;
    $rose(report.loadMovementError) |-> errQ;
  endproperty
  a_lmRise: assert property (p_lmRise)
    else $error("movement error without cause");
  property p_lmWarn;
    $rose(report.loadMovementWarning) |-> mvQ;
  endproperty
  a_lmWarn: assert property (p_lmWarn)
    else $error("movement warning without cause");
  property p_hold;
    $rose(report.zeroSpeedHold) |->
      (report.brakeContactWarning || report.loadMovementWarning) && report.releaseInhibit;
  endproperty
  a_hold: assert property (p_hold)
    else $error("hold without warning or inhibit");
  property p_stop;
    s_stop |=> !report.zeroSpeedHold;
  endproperty
  a_stop: assert property (p_stop)
    else $error("hold not interrupted");
  property p_sticky;
    report.brakeFeedbackError && !s_axi_wvalid && !$past(s_axi_wvalid)
      |=> report.brakeFeedbackError;
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("feedback error dropped");
endmodule : bflw_chk

/* File: bflw_plant_model.sv */
// partner: brake contact, relay feedback and speed sensor
module bflw_plant_model #(
  parameter int OPEN_DLY = 3
) (
  // clock and bench commands
  input wire logic clk_sys,
  input wire logic engaging,
  input wire logic stuck,
  input wire logic [15:0] drift,
  // feedback to the drive
  output logic contactOpen,
  output logic relayOpen,
  output logic [15:0] speedAbs
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  // relay drops at once, contact some cycles later unless stuck
  always_ff @(posedge clk_sys) begin
    cnt <= engaging ? cnt + 1 : 0;
    relayOpen <= engaging;
    contactOpen <= engaging && !stuck && cnt >= OPEN_DLY;
    speedAbs <= drift;
  end
endmodule : bflw_plant_model

/* File: bflw_testbench.sv */
// testbench: register and drive-side tests of the load watch
module testbench
  import bflw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 0, rst = 1, awV = 0, wV = 0, bR = 0, arV = 0, rR = 0, stuck = 0;
  logic [7:0] awA = 0, arA = 0;
  logic [31:0] wD = 0, rD;
  logic awRdy, wRdy, bV, arRdy, rV, cOpen, rOpen;
  logic [1:0] bResp, rResp;
  logic [15:0] drift = 0, spd;
  bflw_drive_t drv = '0, dIn;
  bflw_report_t rpt;
  int fail_count = 0, check_count = 0;

  // ========
  // clock, plant and device
  initial begin
    forever #2 clk_sys = ~clk_sys;
  end
  always_comb begin
    dIn = drv;
    dIn.contactOpen = cOpen;
    dIn.relayOpen = rOpen;
    dIn.speedAbs = spd;
  end
  bflw_plant_model #(.OPEN_DLY(3)) plant (.clk_sys(clk_sys), .engaging(drv.brakeEngaging),
    .stuck(stuck), .drift(drift), .contactOpen(cOpen), .relayOpen(rOpen), .speedAbs(spd));
  bflw_brake_feedback_load_watch #(.STEP_CYCLES(4)) DUT (.clk_sys(clk_sys), .rst(rst),
    .s_axi_awaddr(awA), .s_axi_awvalid(awV), .s_axi_awready(awRdy), .s_axi_wdata(wD),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wV), .s_axi_wready(wRdy), .s_axi_bresp(bResp),
    .s_axi_bvalid(bV), .s_axi_bready(bR), .s_axi_araddr(arA), .s_axi_arvalid(arV),
    .s_axi_arready(arRdy), .s_axi_rdata(rD), .s_axi_rresp(rResp), .s_axi_rvalid(rV),
    .s_axi_rready(rR), .drive(dIn), .report(rpt));

  // ========
  // compare tasks
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: value %h, expected %h", $time, got, exp);
    end
  endtask : chk_val
  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: response %h, expected %h", $time, got, exp);
    end
  endtask : chk_resp

  // ========
  // bus tasks
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
    logic aT, wT, bT;
    logic [1:0] resp;
    bT = 1'b0;
    resp = 2'h0;
    @(posedge clk_sys);
    awA <= a;
    wD <= d;
    awV <= 1'b1;
    wV <= 1'b1;
    bR <= 1'b1;
    for (int n = 0; n < 64 && !bT; n++) begin
      // handshakes sampled where settled, acted on at the next edge
      @(negedge clk_sys);
      aT = awRdy;
      wT = wRdy;
      bT = bV;
      resp = bResp;
      @(posedge clk_sys);
      if (aT) awV <= 1'b0;
      if (wT) wV <= 1'b0;
    end
    bR <= 1'b0;
    if (!bT) begin
      fail_count++;
      $display("Error at %0t: write not answered", $time);
    end
    chk_resp(resp, er);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [31:0] m = 32'hFFFFFFFF, input logic [1:0] er = RESP_OKAY);
    logic aT, rT;
    logic [31:0] data;
    logic [1:0] resp;
    rT = 1'b0;
    data = 32'h00000000;
    resp = 2'h0;
    @(posedge clk_sys);
    arA <= a;
    arV <= 1'b1;
    rR <= 1'b1;
    for (int n = 0; n < 64 && !rT; n++) begin
      // data taken while it stands, before the closing edge
      @(negedge clk_sys);
      aT = arRdy;
      rT = rV;
      data = rD;
      resp = rResp;
      @(posedge clk_sys);
      if (aT) arV <= 1'b0;
    end
    rR <= 1'b0;
    if (!rT) begin
      fail_count++;
      $display("Error at %0t: read not answered", $time);
    end
    chk_val(data & m, e);
    chk_resp(resp, er);
  endtask : rd

  // ========
  // drive-side tasks
  task automatic engage(input logic s);
    @(posedge clk_sys);
    stuck <= s;
    drv.brakeEngaging <= 1'b1;
    drv.brakeSeqActive <= 1'b1;
    repeat (6) @(posedge clk_sys);
    drv.engageTimeEnd <= 1'b1;
    @(posedge clk_sys);
    drv.engageTimeEnd <= 1'b0;
    drv.brakeEngaging <= 1'b0;
    drv.brakeSeqActive <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask : engage
  task automatic move();
    drift <= 16'h0101;
    repeat (3) @(posedge clk_sys);
    drift <= 16'h0000;
    repeat (3) @(posedge clk_sys);
  endtask : move
  task automatic stopHold(input int i);
    {drv.errorTrig, drv.driveLock, drv.stoActive, drv.newRunCmd} <= 4'(1 << i);
    @(posedge clk_sys);
    {drv.errorTrig, drv.driveLock, drv.stoActive, drv.newRunCmd} <= 4'h0;
    repeat (2) @(posedge clk_sys);
  endtask : stopHold
  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_of_test

  // ========
  // watchdog
  initial begin
    #200000;
    fail_count++;
    $display("Error at %0t: watchdog expired", $time);
    end_of_test();
  end

  // ========
  // test sequence
  initial begin
    drv.opState <= OPST_OP_ENABLED;
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    rd(ADDR_THRESH, 32'h0);
    rd(ADDR_STATUS, 32'h20);
    rd(8'h10, 32'h0, 32'hFFFFFFFF, RESP_SLVERR);
    wr(8'h14, 32'h1, RESP_SLVERR);
    wr(ADDR_CTRL, 32'h2, RESP_SLVERR);
    wr(ADDR_THRESH, 32'h100);
    wr(ADDR_CTRL, 32'h2);
    wr(ADDR_THRESH, 32'h0, RESP_SLVERR);
    rd(ADDR_THRESH, 32'h100);
    wr(ADDR_RESTART, 32'h2);
    $display("test registers done");
    wr(ADDR_CTRL, 32'h0);
    engage(1'b1);
    rd(ADDR_STATUS, 32'h0, 32'h1F);
    drv.closedLoop <= 1'b1;
    engage(1'b0);
    rd(ADDR_STATUS, 32'h0, 32'h1F);
    engage(1'b1);
    rd(ADDR_STATUS, 32'h1, 32'h1F);
    chk_val({26'h0, rpt}, 32'h20);
    wr(ADDR_CTRL, 32'h100);
    rd(ADDR_STATUS, 32'h0, 32'h1F);
    wr(ADDR_CTRL, 32'h1);
    engage(1'b1);
    rd(ADDR_STATUS, 32'h14, 32'h1F);
    chk_val({26'h0, rpt}, 32'h0B);
    stopHold(0);
    wr(ADDR_STATUS, 32'h4);
    rd(ADDR_STATUS, 32'h0, 32'h1F);
    $display("test brake feedback done");
    wr(ADDR_CTRL, 32'h0);
    drift <= 16'h0101;
    engage(1'b0);
    chk_val({26'h0, rpt}, 32'h0);
    drift <= 16'h0100;
    repeat (12) @(posedge clk_sys);
    chk_val({26'h0, rpt}, 32'h0);
    move();
    chk_val({26'h0, rpt}, 32'h10);
    wr(ADDR_CTRL, 32'h100);
    drv.motionCmd <= 1'b1;
    move();
    chk_val({26'h0, rpt}, 32'h0);
    drv.motionCmd <= 1'b0;
    for (int s = 2; s <= 8; s++) begin
      drv.opState <= 4'(s);
      move();
      chk_val({26'h0, rpt}, (s == 2 || s > 6) ? 32'h0 : 32'h10);
      wr(ADDR_CTRL, 32'h100);
    end
    drv.opState <= OPST_OP_ENABLED;
    $display("test movement error done");
    wr(ADDR_CTRL, 32'h2);
    for (int i = 0; i < 3; i++) begin
      move();
      chk_val({26'h0, rpt}, 32'h07);
      stopHold(i);
      chk_val({26'h0, rpt}, 32'h04);
      wr(ADDR_STATUS, 32'h8);
    end
    // cia402 profile without priority: ready state is not watched
    drv.cia402Profile <= 1'b1;
    drv.opState <= OPST_READY;
    move();
    chk_val({26'h0, rpt}, 32'h0);
    drv.cia402Profile <= 1'b0;
    move();
    chk_val({26'h0, rpt}, 32'h07);
    stopHold(3);
    chk_val({26'h0, rpt}, 32'h04);
    wr(ADDR_STATUS, 32'h8);
    // priority option: hold ignores errors, watch runs in switch-on-disabled
    wr(ADDR_CTRL, 32'h6);
    drv.opState <= OPST_SWITCH_ON_DIS;
    move();
    chk_val({26'h0, rpt}, 32'h07);
    stopHold(3);
    chk_val({26'h0, rpt}, 32'h07);
    stopHold(1);
    chk_val({26'h0, rpt}, 32'h04);
    $display("test movement hold done");
    end_of_test();
  end
endmodule : testbench

bind bflw_brake_feedback_load_watch bflw_chk u_chk (.clk_sys(clk_sys), .rst(rst),
  .s_axi_wvalid(s_axi_wvalid), .drive(drive), .report(report));
